// [hdl/oscsc_pkg.sv]
// constants and types for the oscillator start-up control block
package oscsc_pkg;

	// ************************************************************
	// timing
	// ************************************************************
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned HF_SETTLE_MIN_NS = 2000000;
	// strictly more than the minimum, so one extra cycle
	localparam int unsigned HF_SETTLE_MIN_CYC = HF_SETTLE_MIN_NS / CLK_PERIOD_NS + 1;
	localparam int unsigned STEP_US = 250;
	localparam int unsigned RC_STEP_DIV = 4000;

	// ************************************************************
	// register indices (byte address is four times the index)
	// ************************************************************
	localparam logic [31:0] SYS_STATUS_IDX = 32'h5000_0014;
	localparam logic [31:0] TRIM_TIMING_IDX = 32'h5000_0016;
	localparam logic [31:0] LF_CTRL_IDX = 32'h5000_0020;
	localparam logic [31:0] HF_CTRL_IDX = 32'h5000_0022;
	localparam logic [31:0] RCX_CTRL_IDX = 32'h5000_0024;
	localparam int unsigned DEC_W = 10;

	// ************************************************************
	// reset values and writable masks
	// ************************************************************
	localparam logic [15:0] TRIM_TIMING_RST = 16'h00a2;
	localparam logic [15:0] LF_CTRL_RST = 16'h079c;
	localparam logic [15:0] HF_CTRL_RST = 16'h00a0;
	localparam logic [15:0] RCX_CTRL_RST = 16'h0178;
	localparam logic [15:0] TRIM_TIMING_MASK = 16'h00ff;
	localparam logic [15:0] LF_CTRL_MASK = 16'h1fff;
	localparam logic [15:0] HF_CTRL_MASK = 16'h03ff;
	localparam logic [15:0] RCX_CTRL_MASK = 16'h1fff;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int unsigned ST_SETTLED = 7;
	localparam int unsigned ST_TRIM_READY = 6;
	localparam int unsigned ST_DBG_UP = 5;
	localparam int unsigned ST_DBG_DOWN = 4;
	localparam int unsigned ST_PER_UP = 3;
	localparam int unsigned ST_PER_DOWN = 2;
	localparam int unsigned ST_RAD_UP = 1;
	localparam int unsigned ST_RAD_DOWN = 0;
	localparam int unsigned TT_TRIM_LSB = 4;
	localparam int unsigned TT_SETTLE_LSB = 0;
	localparam int unsigned LF_AMPREG = 12;
	localparam int unsigned LF_RC_TRIM_LSB = 8;
	localparam int unsigned LF_RC_ON = 7;
	localparam int unsigned LF_CUR_LSB = 3;
	localparam int unsigned LF_RBIAS_LSB = 1;
	localparam int unsigned LF_XTAL_ON = 0;
	localparam int unsigned HF_NOISE = 9;
	localparam int unsigned HF_BIAS_HOLD = 8;
	localparam int unsigned HF_CUR_LSB = 5;
	localparam int unsigned HF_RC_TRIM_LSB = 1;
	localparam int unsigned HF_RC_ON = 0;
	localparam int unsigned RCX_SELECT = 12;
	localparam int unsigned RCX_ON = 11;
	localparam int unsigned RCX_LOWF = 10;
	localparam int unsigned RCX_BIAS_LSB = 8;
	localparam int unsigned RCX_TEMP_LSB = 4;
	localparam int unsigned RCX_TRIM_LSB = 0;

	// ************************************************************
	// start-up sequence states
	// ************************************************************
	typedef enum logic [1:0] {
		OSCSC_IDLE = 2'b00,
		OSCSC_TRIM_WAIT = 2'b01,
		OSCSC_SETTLE_WAIT = 2'b10,
		OSCSC_DONE = 2'b11
	} oscsc_state_t;

endpackage

// [hdl/oscsc_top.sv]
// oscillator start-up control: register file and crystal start-up timer
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
module oscsc_top
	import oscsc_pkg::*;
#(
	parameter int unsigned TRIM_W = 8,
	parameter int unsigned STEP_DIV = RC_STEP_DIV,
	parameter int unsigned MIN_SETTLE_CYC = HF_SETTLE_MIN_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hf_crystal_en,
	input wire logic hf_rc_clk_tick,
	input wire logic [TRIM_W-1:0] frequency_trim_value,
	input wire logic debug_domain_pwr,
	input wire logic periph_domain_pwr,
	input wire logic radio_domain_pwr,
	output logic [TRIM_W-1:0] hf_crystal_applied_trim,
	output logic hf_crystal_settled_flag,
	output logic hf_crystal_trim_ready_flag,
	output logic lf_crystal_amp_reg_off,
	output logic [3:0] lf_rc_trim,
	output logic lf_rc_on,
	output logic [3:0] lf_crystal_bias_current,
	output logic [1:0] lf_crystal_bias_resistor,
	output logic lf_crystal_on,
	output logic hf_crystal_noise_filter_on,
	output logic hf_crystal_bias_hold_on,
	output logic [2:0] hf_crystal_bias_current,
	output logic [3:0] hf_rc_trim,
	output logic hf_rc_on,
	output logic extra_rc_select,
	output logic extra_rc_on,
	output logic extra_rc_low_freq,
	output logic [1:0] extra_rc_bias,
	output logic [3:0] extra_rc_temp_control,
	output logic [3:0] extra_rc_trim
);

	// ************************************************************
	// functions
	// ************************************************************
	function automatic logic reg_hit(input logic [31:0] addr, input logic [31:0] idx);
		reg_hit = (addr[DEC_W+1:2] == idx[DEC_W-1:0]) && (addr[1:0] == 2'b00);
	endfunction

	function automatic logic [15:0] wr_merge(input logic [15:0] old,
		input logic [31:0] wdata, input logic [3:0] strb, input logic [15:0] mask);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
		wr_merge = (old & ~lanes) | (wdata[15:0] & lanes);
	endfunction

	localparam int unsigned DIV_W = $clog2(STEP_DIV);
	localparam int unsigned MIN_W = $clog2(MIN_SETTLE_CYC + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(STEP_DIV - 1);
	localparam logic [MIN_W-1:0] MIN_LAST = MIN_W'(MIN_SETTLE_CYC);

	logic [15:0] trim_timing_r;
	logic [15:0] lf_ctrl_r;
	logic [15:0] hf_ctrl_r;
	logic [15:0] rcx_ctrl_r;
	logic [7:0] status_val;
	logic [5:0] dom_r;
	logic [31:0] prdata_r;
	logic pslverr_r;
	logic wr_acc;
	logic hit_status;
	logic hit_timing;
	logic hit_lf;
	logic hit_hf;
	logic hit_rcx;
	logic hit_any;
	logic [DIV_W-1:0] div_cnt_r;
	logic step_tick;
	logic en_d_r;
	logic en_rise;
	oscsc_state_t state_r;
	oscsc_state_t state_nxt;
	logic [3:0] step_cnt_r;
	logic [3:0] step_cnt_nxt;
	logic [MIN_W-1:0] min_cnt_r;
	logic min_done;
	logic [TRIM_W-1:0] applied_trim_r;
	logic apply_now;
	logic settled_r;
	logic trim_ready_r;
	logic [3:0] trim_code;
	logic [3:0] settle_code;

	// ************************************************************
	// apb decode
	// ************************************************************
	assign hit_status = reg_hit(paddr, SYS_STATUS_IDX);
	assign hit_timing = reg_hit(paddr, TRIM_TIMING_IDX);
	assign hit_lf = reg_hit(paddr, LF_CTRL_IDX);
	assign hit_hf = reg_hit(paddr, HF_CTRL_IDX);
	assign hit_rcx = reg_hit(paddr, RCX_CTRL_IDX);
	assign hit_any = hit_status | hit_timing | hit_lf | hit_hf | hit_rcx;
	assign wr_acc = psel & penable & pwrite;
	// zero wait state slave
	assign pready = 1'b1;
	assign prdata = prdata_r;
	assign pslverr = pslverr_r;

	// read data is presented during the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			if (hit_status) begin
				prdata_r <= {24'h00_0000, status_val};
			end else if (hit_timing) begin
				prdata_r <= {16'h0000, trim_timing_r};
			end else if (hit_lf) begin
				prdata_r <= {16'h0000, lf_ctrl_r};
			end else if (hit_hf) begin
				prdata_r <= {16'h0000, hf_ctrl_r};
			end else if (hit_rcx) begin
				prdata_r <= {16'h0000, rcx_ctrl_r};
			end else begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	// unmapped addresses answer with an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr_r <= 1'b0;
		end else begin
			pslverr_r <= psel & ~penable & ~hit_any;
		end
	end

	// ************************************************************
	// control registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_timing_r <= TRIM_TIMING_RST;
		end else if (wr_acc & hit_timing) begin
			trim_timing_r <= wr_merge(trim_timing_r, pwdata, pstrb, TRIM_TIMING_MASK);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lf_ctrl_r <= LF_CTRL_RST;
		end else if (wr_acc & hit_lf) begin
			lf_ctrl_r <= wr_merge(lf_ctrl_r, pwdata, pstrb, LF_CTRL_MASK);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hf_ctrl_r <= HF_CTRL_RST;
		end else if (wr_acc & hit_hf) begin
			hf_ctrl_r <= wr_merge(hf_ctrl_r, pwdata, pstrb, HF_CTRL_MASK);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rcx_ctrl_r <= RCX_CTRL_RST;
		end else if (wr_acc & hit_rcx) begin
			rcx_ctrl_r <= wr_merge(rcx_ctrl_r, pwdata, pstrb, RCX_CTRL_MASK);
		end
	end

	assign trim_code = trim_timing_r[TT_TRIM_LSB +: 4];
	assign settle_code = trim_timing_r[TT_SETTLE_LSB +: 4];

	// ************************************************************
	// oscillator control fields
	// ************************************************************
	// 32 kHz amplitude regulation bit kept for software
	assign lf_crystal_amp_reg_off = lf_ctrl_r[LF_AMPREG];
	assign lf_rc_trim = lf_ctrl_r[LF_RC_TRIM_LSB +: 4];
	assign lf_rc_on = lf_ctrl_r[LF_RC_ON];
	assign lf_crystal_on = lf_ctrl_r[LF_XTAL_ON];
	assign lf_crystal_bias_current = lf_ctrl_r[LF_CUR_LSB +: 4];
	assign lf_crystal_bias_resistor = lf_ctrl_r[LF_RBIAS_LSB +: 2];
	assign hf_crystal_noise_filter_on = hf_ctrl_r[HF_NOISE];
	assign hf_crystal_bias_hold_on = hf_ctrl_r[HF_BIAS_HOLD];
	assign hf_crystal_bias_current = hf_ctrl_r[HF_CUR_LSB +: 3];
	assign hf_rc_trim = hf_ctrl_r[HF_RC_TRIM_LSB +: 4];
	assign hf_rc_on = hf_ctrl_r[HF_RC_ON];
	assign extra_rc_select = rcx_ctrl_r[RCX_SELECT];
	assign extra_rc_on = rcx_ctrl_r[RCX_ON];
	assign extra_rc_low_freq = rcx_ctrl_r[RCX_LOWF];
	assign extra_rc_bias = rcx_ctrl_r[RCX_BIAS_LSB +: 2];
	assign extra_rc_temp_control = rcx_ctrl_r[RCX_TEMP_LSB +: 4];
	assign extra_rc_trim = rcx_ctrl_r[RCX_TRIM_LSB +: 4];

	// ************************************************************
	// step tick
	// ************************************************************
	// count rc clock edges, free running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt_r <= '0;
		end else if (hf_rc_clk_tick) begin
			if (div_cnt_r == DIV_LAST) begin
				div_cnt_r <= '0;
			end else begin
				div_cnt_r <= div_cnt_r + 1'b1;
			end
		end
	end
	assign step_tick = hf_rc_clk_tick && (div_cnt_r == DIV_LAST);

	// ************************************************************
	// start-up sequence
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_d_r <= 1'b0;
		end else begin
			en_d_r <= hf_crystal_en;
		end
	end
	assign en_rise = hf_crystal_en & ~en_d_r;

	always_comb begin
		state_nxt = state_r;
		step_cnt_nxt = step_cnt_r;
		apply_now = 1'b0;
		case (state_r)
			OSCSC_IDLE: begin
				if (en_rise) begin
					// code zero applies trim at once
					if (trim_code == 4'h0) begin
						apply_now = 1'b1;
						state_nxt = OSCSC_SETTLE_WAIT;
						step_cnt_nxt = settle_code;
					end else begin
						state_nxt = OSCSC_TRIM_WAIT;
						step_cnt_nxt = trim_code;
					end
				end
			end
			OSCSC_TRIM_WAIT: begin
				if (step_tick) begin
					if (step_cnt_r == 4'h1) begin
						apply_now = 1'b1;
						state_nxt = OSCSC_SETTLE_WAIT;
						step_cnt_nxt = settle_code;
					end else begin
						step_cnt_nxt = step_cnt_r - 4'h1;
					end
				end
			end
			OSCSC_SETTLE_WAIT: begin
				// zero settle code finishes at once
				if (step_cnt_r == 4'h0) begin
					state_nxt = OSCSC_DONE;
				end else if (step_tick) begin
					step_cnt_nxt = step_cnt_r - 4'h1;
				end
			end
			OSCSC_DONE: state_nxt = OSCSC_DONE;
			default: begin
				state_nxt = OSCSC_IDLE;
			end
		endcase
		// disable aborts, a new enable restarts
		if (!hf_crystal_en) begin
			state_nxt = OSCSC_IDLE;
			apply_now = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= OSCSC_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_cnt_r <= 4'h0;
		end else begin
			step_cnt_r <= step_cnt_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			min_cnt_r <= '0;
		end else if (!hf_crystal_en || en_rise) begin
			min_cnt_r <= '0;
		end else if (min_cnt_r != MIN_LAST) begin
			min_cnt_r <= min_cnt_r + 1'b1;
		end
	end
	assign min_done = (min_cnt_r == MIN_LAST);

	// latch the trim value when applied
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			applied_trim_r <= '0;
		end else if (apply_now) begin
			applied_trim_r <= frequency_trim_value;
		end
	end

	// settled needs sequence done and minimum time
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			settled_r <= 1'b0;
		end else begin
			settled_r <= (state_r == OSCSC_DONE) && min_done && hf_crystal_en;
		end
	end

	// trim ready compares applied with programmed after apply; high in idle, low from enable rise until apply
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_ready_r <= 1'b1;
		end else if (state_r == OSCSC_SETTLE_WAIT || state_r == OSCSC_DONE) begin
			trim_ready_r <= (applied_trim_r == frequency_trim_value);
		end else begin
			trim_ready_r <= (state_r == OSCSC_IDLE) && !en_rise;
		end
	end

	assign hf_crystal_applied_trim = applied_trim_r;
	assign hf_crystal_settled_flag = settled_r;
	assign hf_crystal_trim_ready_flag = trim_ready_r;

	// ************************************************************
	// status
	// ************************************************************
	// domain pairs, down bits reset high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dom_r <= 6'h15;
		end else begin
			dom_r[ST_DBG_UP] <= debug_domain_pwr;
			dom_r[ST_DBG_DOWN] <= ~debug_domain_pwr;
			dom_r[ST_PER_UP] <= periph_domain_pwr;
			dom_r[ST_PER_DOWN] <= ~periph_domain_pwr;
			dom_r[ST_RAD_UP] <= radio_domain_pwr;
			dom_r[ST_RAD_DOWN] <= ~radio_domain_pwr;
		end
	end
	assign status_val = {settled_r, trim_ready_r, dom_r};

endmodule

// [test/oscsc_properties.sv]
// port-level checks for the oscillator start-up control block
`timescale 1ns/1ps
module oscsc_properties
	import oscsc_pkg::*;
#(
	parameter int unsigned TRIM_W = 8,
	parameter int unsigned MIN_SETTLE_CYC = HF_SETTLE_MIN_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic hf_crystal_en,
	input wire logic [TRIM_W-1:0] frequency_trim_value,
	input wire logic [TRIM_W-1:0] hf_crystal_applied_trim,
	input wire logic hf_crystal_settled_flag,
	input wire logic hf_crystal_trim_ready_flag,
	input wire logic [3:0] lf_rc_trim,
	input wire logic lf_rc_on,
	input wire logic [2:0] hf_crystal_bias_current,
	input wire logic [3:0] hf_rc_trim,
	input wire logic hf_rc_on,
	input wire logic extra_rc_select
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr_acc;
	logic [31:0] en_cnt_r;
	assign wr_acc = psel && penable && pwrite;
	// ************************************************************
	// crystal enable time
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			en_cnt_r <= '0;
		else if (!hf_crystal_en)
			en_cnt_r <= '0;
		else
			en_cnt_r <= en_cnt_r + 32'h1;
	end
	// ************************************************************
	// assertions
	// ************************************************************
	a_settle_min: assert property ($rose(hf_crystal_settled_flag) |-> en_cnt_r >= MIN_SETTLE_CYC)
		else $error("settled flag rose too early");
	a_settle_clear: assert property (!hf_crystal_en ##1 !hf_crystal_en |-> !hf_crystal_settled_flag)
		else $error("settled flag kept while disabled");
	a_ready_idle: assert property (!hf_crystal_en [*3] |-> hf_crystal_trim_ready_flag)
		else $error("trim ready low while idle");
	a_trim_source: assert property ($changed(hf_crystal_applied_trim) |->
		hf_crystal_applied_trim == $past(frequency_trim_value) && $past(hf_crystal_en))
		else $error("applied trim not the programmed value");
	a_hf_fields: assert property (wr_acc && paddr[11:0] == 12'h088 && pstrb[0] |=>
		hf_rc_trim == $past(pwdata[4:1]) && hf_crystal_bias_current == $past(pwdata[7:5]))
		else $error("hf fields not written");
	a_lf_trim: assert property (wr_acc && paddr[11:0] == 12'h080 && pstrb[1] |=>
		lf_rc_trim == $past(pwdata[11:8]))
		else $error("lf rc trim not written");
	a_hf_rc_on: assert property ($changed(hf_rc_on) |->
		$past(wr_acc && paddr[11:0] == 12'h088 && pstrb[0]))
		else $error("hf rc enable changed without write");
	a_lf_rc_on: assert property ($changed(lf_rc_on) |->
		$past(wr_acc && paddr[11:0] == 12'h080 && pstrb[0]))
		else $error("lf rc enable changed without write");
	a_rcx_select: assert property ($changed(extra_rc_select) |->
		$past(wr_acc && paddr[11:0] == 12'h090 && pstrb[1]))
		else $error("rc source select changed without write");
	c_settled: cover property ($rose(hf_crystal_settled_flag));
	c_applied: cover property ($changed(hf_crystal_applied_trim));
	c_restart: cover property ($rose(hf_crystal_en) ##[1:8] $fell(hf_crystal_en));
endmodule

bind oscsc_top oscsc_properties #(.TRIM_W(TRIM_W), .MIN_SETTLE_CYC(MIN_SETTLE_CYC)) chk_u (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .hf_crystal_en,
	.frequency_trim_value, .hf_crystal_applied_trim, .hf_crystal_settled_flag,
	.hf_crystal_trim_ready_flag, .lf_rc_trim, .lf_rc_on, .hf_crystal_bias_current,
	.hf_rc_trim, .hf_rc_on, .extra_rc_select);

// [test/testbench.sv]
// self-checking bench for the oscillator start-up control block
`timescale 1ns/1ps
module testbench
	import oscsc_pkg::*;
;
	localparam int STEP_CYC = 8;
	logic pclk, presetn, psel, penable, pwrite, hf_crystal_en;
	logic hf_rc_clk_tick = 1'b0;
	logic dbg_pwr, per_pwr, rad_pwr, pready, pslverr, settled, tready, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [7:0] trim_in, applied;
	wire [12:0] lf_o, rcx_o;
	wire [9:0] hf_o;
	logic [31:0] regs[4] = '{32'h58, 32'h80, 32'h88, 32'h90};
	logic [15:0] masks[4] = '{TRIM_TIMING_MASK, LF_CTRL_MASK, HF_CTRL_MASK, RCX_CTRL_MASK};
	logic [3:0] tc[5] = '{4'h0, 4'h1, 4'h2, 4'ha, 4'h1};
	logic [3:0] sc[5] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h0};
	int errors, checks, n, m;
	oscsc_top #(.STEP_DIV(4), .MIN_SETTLE_CYC(10)) dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hf_crystal_en(hf_crystal_en), .hf_rc_clk_tick(hf_rc_clk_tick),
		.frequency_trim_value(trim_in), .debug_domain_pwr(dbg_pwr),
		.periph_domain_pwr(per_pwr), .radio_domain_pwr(rad_pwr),
		.hf_crystal_applied_trim(applied), .hf_crystal_settled_flag(settled),
		.hf_crystal_trim_ready_flag(tready), .lf_crystal_amp_reg_off(lf_o[12]),
		.lf_rc_trim(lf_o[11:8]), .lf_rc_on(lf_o[7]), .lf_crystal_bias_current(lf_o[6:3]),
		.lf_crystal_bias_resistor(lf_o[2:1]), .lf_crystal_on(lf_o[0]),
		.hf_crystal_noise_filter_on(hf_o[9]), .hf_crystal_bias_hold_on(hf_o[8]),
		.hf_crystal_bias_current(hf_o[7:5]), .hf_rc_trim(hf_o[4:1]), .hf_rc_on(hf_o[0]),
		.extra_rc_select(rcx_o[12]), .extra_rc_on(rcx_o[11]), .extra_rc_low_freq(rcx_o[10]),
		.extra_rc_bias(rcx_o[9:8]), .extra_rc_temp_control(rcx_o[7:4]),
		.extra_rc_trim(rcx_o[3:0]));
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) hf_rc_clk_tick <= ~hf_rc_clk_tick;
	task automatic report_and_stop();
		if (errors == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// one apb transfer; read data and error taken at the ready edge
	task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input string name, input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0, 4'h0);
		chk(name, exp, rd);
	endtask
	initial begin
		#400000;
		errors++;
		report_and_stop();
	end
	initial begin
		{psel, penable, pwrite, hf_crystal_en} = '0;
		{dbg_pwr, per_pwr, rad_pwr} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		trim_in = '0;
		errors = 0;
		checks = 0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("status", 32'h50, 32'h0055);
		rdchk("trim_timing", 32'h58, 32'h00a2);
		rdchk("lf_ctrl", 32'h80, 32'h079c);
		rdchk("hf_ctrl", 32'h88, 32'h00a0);
		rdchk("rcx_ctrl", 32'h90, 32'h0178);
		chk("lf_out", 32'h079c, 32'(lf_o));
		chk("hf_out", 32'h00a0, 32'(hf_o));
		chk("rcx_out", 32'h0178, 32'(rcx_o));
		{dbg_pwr, per_pwr, rad_pwr} <= 3'b101;
		rdchk("status_dom", 32'h50, 32'h0066);
		{dbg_pwr, per_pwr, rad_pwr} <= 3'b010;
		apb(1'b1, 32'h50, 32'hffff, 4'hf);
		rdchk("status_ro", 32'h50, 32'h0059);
		foreach (regs[i]) begin
			apb(1'b1, regs[i], 32'hffff_ffff, 4'hf);
			rdchk("rw_ones", regs[i], 32'(masks[i]));
			apb(1'b1, regs[i], 32'h0, 4'h1);
			rdchk("rw_lane", regs[i], 32'(masks[i] & 16'hff00));
		end
		apb(1'b1, 32'h80, 32'h0a5b, 4'h3); // crystal fitted, amp reg kept on
		apb(1'b1, 32'h88, 32'h02b6, 4'h3); // bias hold off before sleep
		apb(1'b1, 32'h90, 32'h1469, 4'h3);
		@(posedge pclk);
		chk("lf_out", 32'h0a5b, 32'(lf_o));
		chk("hf_out", 32'h02b6, 32'(hf_o));
		chk("rcx_out", 32'h1469, 32'(rcx_o));
		apb(1'b1, 32'ha0, 32'hffff, 4'hf);
		chk("slverr_unmapped", 32'h1, 32'(err));
		apb(1'b1, 32'h8a, 32'hffff, 4'hf);
		chk("slverr_misaligned", 32'h1, 32'(err));
		rdchk("hf_kept", 32'h88, 32'h02b6);
		chk("slverr_mapped", 32'h0, 32'(err));
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 32'h58, 32'({tc[i], sc[i]}), 4'h1);
			hf_crystal_en <= 1'b1;
			repeat (6) @(posedge pclk);
			hf_crystal_en <= 1'b0;
			repeat (3) @(posedge pclk);
			hf_crystal_en <= 1'b1;
			trim_in <= 8'h30 + 8'(i);
			repeat (3) @(posedge pclk);
			if (tc[i] > 4'h1)
				chk("ready_wait", 32'h0, 32'(tready));
			n = 3;
			while (applied !== trim_in && n < 400) begin
				@(posedge pclk);
				n++;
			end
			chk("apply_time", 32'h1, 32'(n <= tc[i] * STEP_CYC + 3 &&
				n + STEP_CYC >= tc[i] * STEP_CYC));
			m = n;
			while (settled !== 1'b1 && m < 400) begin
				@(posedge pclk);
				m++;
			end
			chk("settle_time", 32'h1, 32'(m >= 11 && (m <= 14 ||
				(m <= n + sc[i] * STEP_CYC + 4 && m + STEP_CYC >= n + sc[i] * STEP_CYC))));
			chk("ready_done", 32'h1, 32'(tready));
			rdchk("status_set", 32'h50, 32'h00d9);
			hf_crystal_en <= 1'b0;
			repeat (3) @(posedge pclk);
			chk("settled_off", 32'h0, 32'(settled));
			chk("ready_off", 32'h1, 32'(tready));
		end
		report_and_stop();
	end
endmodule
